// [logic/aodr_regs.svh]
/*
  Register offsets, field positions and reset values of the analog output
  and digital port register bank. Included by the package and the design.
*/
`ifndef AODR_REGS_SVH
`define AODR_REGS_SVH
`define AODR_OFS_CMD1 5'h01
`define AODR_OFS_DAC0_LO 5'h04
`define AODR_OFS_DAC0_HI 5'h05
`define AODR_OFS_DAC1_LO 5'h06
`define AODR_OFS_DAC1_HI 5'h07
`define AODR_OFS_CMD2 5'h0E
`define AODR_OFS_PORT_FIRST 5'h10
`define AODR_OFS_PORT_SECOND 5'h11
`define AODR_OFS_PORT_CFG 5'h13
`define AODR_OFS_CAL_READ 5'h1D
`define AODR_CMD1_TWOS_CH0 4
`define AODR_CMD1_TWOS_CH1 5
`define AODR_CMD2_RANGE_CH0 2
`define AODR_CMD2_RANGE_CH1 3
`define AODR_CFG_MODE_SET 7
`define AODR_CFG_FIRST_IN 4
`define AODR_CFG_SECOND_IN 1
`define AODR_CFG_MODE_MASK 8'h64
`define AODR_CODE_HI_MSB 3
`define AODR_RANGE_RESET 1'h1
`define AODR_TWOS_RESET 1'h0
`define AODR_PORT_RESET 8'h00
`define AODR_CODE_RESET 12'h000
`endif

// [logic/aodr_dac_channel.sv]
/*
  One analog output channel: stages the low byte and loads the full code
  on a high-byte write. Assumes one-cycle write strobes on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aodr_regs.svh"

module aodr_dac_channel #(
  parameter int CODE_W = 12
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Write strobes and data
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  // Loaded code and update pulse
  output logic [CODE_W-1:0] o_code,
  output logic o_update
);
  logic [7:0] lo_stage_q;
  logic [CODE_W-1:0] code_q;
  logic update_q;
  wire logic [CODE_W-1:0] code_d = {i_wdata[`AODR_CODE_HI_MSB:0], lo_stage_q};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) lo_stage_q <= 8'h00;
    else if (i_wr_lo) lo_stage_q <= i_wdata;
  end

  // Update on high byte; staged byte joins it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      code_q <= `AODR_CODE_RESET;
      update_q <= 1'b0;
    end else begin
      update_q <= i_wr_hi;
      if (i_wr_hi) code_q <= code_d;
    end
  end

  assign o_code = code_q;
  assign o_update = update_q;
endmodule : aodr_dac_channel
`default_nettype wire

// [logic/aodr_register_bank.sv]
/*
  Byte-wide host register bank of a two-channel analog output and
  two-port digital I/O board. Assumes the host bus strobes arrive
  synchronous to i_clk_sys, one cycle per access; pins are asynchronous.
*/
// Summary of operation
// - Calibration readback returns the EEPROM serial output on bit 0.
// - Each channel assembles a 12-bit code from two byte writes.
// - Outputs change only on a high-byte write, never a low-byte write alone.
// - High byte bits 3..0 are code 11..8; bits 7..4 are ignored.
// - Low-byte write stores code bits 7..0.
// - Both channels power up unipolar.
// - First port reads live lines; writes drive only when output.
// - Second port reads live lines; writes drive only when output.
// - Only plain unhandshaked port mode exists.
// - Config word bit 7 set; bit 4 first port, bit 1 second, 1 input.
// - An accepted config word (bit 7 set, bits 6, 5, 2 clear) clears both port output latches.
// - No interrupts are produced.
// - Per-channel bit selects two's complement or straight binary.
// - Per-channel bit selects unipolar when set, bipolar when clear.
`timescale 1ns/100ps
`default_nettype none
`include "aodr_regs.svh"

package aodr_pkg;
  typedef logic [4:0] aodr_addr_t;
  typedef logic [7:0] aodr_byte_t;
endpackage : aodr_pkg

module aodr_register_bank #(
  parameter int CODE_W = 12
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Host byte bus
  input wire aodr_pkg::aodr_addr_t i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire aodr_pkg::aodr_byte_t i_wdata,
  output aodr_pkg::aodr_byte_t o_rdata,
  output logic o_rvalid,
  // Analog channels
  output logic [CODE_W-1:0] o_ch0_code,
  output logic [CODE_W-1:0] o_ch1_code,
  output logic o_ch0_update,
  output logic o_ch1_update,
  output logic o_twos_complement_select_ch0,
  output logic o_twos_complement_select_ch1,
  output logic o_range_select_ch0,
  output logic o_range_select_ch1,
  // EEPROM serial output pin
  input wire logic i_eeprom_serial_readback_bit,
  // Digital port pins
  input wire aodr_pkg::aodr_byte_t i_first_port_lines,
  output aodr_pkg::aodr_byte_t o_first_port_lines,
  output aodr_pkg::aodr_byte_t o_first_port_lines_oe,
  input wire aodr_pkg::aodr_byte_t i_second_port_lines,
  output aodr_pkg::aodr_byte_t o_second_port_lines,
  output aodr_pkg::aodr_byte_t o_second_port_lines_oe
);
  import aodr_pkg::*;

  // Address decode
  wire logic wr_cmd1 = i_wr && (i_addr == `AODR_OFS_CMD1);
  wire logic wr_cmd2 = i_wr && (i_addr == `AODR_OFS_CMD2);
  wire logic wr_d0lo = i_wr && (i_addr == `AODR_OFS_DAC0_LO);
  wire logic wr_d0hi = i_wr && (i_addr == `AODR_OFS_DAC0_HI);
  wire logic wr_d1lo = i_wr && (i_addr == `AODR_OFS_DAC1_LO);
  wire logic wr_d1hi = i_wr && (i_addr == `AODR_OFS_DAC1_HI);
  wire logic wr_pa = i_wr && (i_addr == `AODR_OFS_PORT_FIRST);
  wire logic wr_pb = i_wr && (i_addr == `AODR_OFS_PORT_SECOND);
  // Only mode-set words with basic-mode bits clear are accepted
  wire logic wr_cfg = i_wr && (i_addr == `AODR_OFS_PORT_CFG)
    && i_wdata[`AODR_CFG_MODE_SET] && ((i_wdata & `AODR_CFG_MODE_MASK) == 8'h00);

  // Pin synchronisers
  aodr_byte_t pa_meta_q, pa_sync_q, pb_meta_q, pb_sync_q;
  logic prom_meta_q, prom_sync_q;
  always_ff @(posedge i_clk_sys) begin
    pa_meta_q <= i_first_port_lines;
    pa_sync_q <= pa_meta_q;
    pb_meta_q <= i_second_port_lines;
    pb_sync_q <= pb_meta_q;
    prom_meta_q <= i_eeprom_serial_readback_bit;
    prom_sync_q <= prom_meta_q;
  end

  // Analog channels
  aodr_dac_channel #(.CODE_W(CODE_W)) u_ch0 (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_wr_lo(wr_d0lo),
    .i_wr_hi(wr_d0hi),
    .i_wdata(i_wdata),
    .o_code(o_ch0_code),
    .o_update(o_ch0_update)
  );
  aodr_dac_channel #(.CODE_W(CODE_W)) u_ch1 (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_wr_lo(wr_d1lo),
    .i_wr_hi(wr_d1hi),
    .i_wdata(i_wdata),
    .o_code(o_ch1_code),
    .o_update(o_ch1_update)
  );

  logic twos0_q, twos1_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      twos0_q <= `AODR_TWOS_RESET;
      twos1_q <= `AODR_TWOS_RESET;
    end else if (wr_cmd1) begin
      twos0_q <= i_wdata[`AODR_CMD1_TWOS_CH0];
      twos1_q <= i_wdata[`AODR_CMD1_TWOS_CH1];
    end
  end
  assign o_twos_complement_select_ch0 = twos0_q;
  assign o_twos_complement_select_ch1 = twos1_q;

  logic range0_q, range1_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      range0_q <= `AODR_RANGE_RESET;
      range1_q <= `AODR_RANGE_RESET;
    end else if (wr_cmd2) begin
      range0_q <= i_wdata[`AODR_CMD2_RANGE_CH0];
      range1_q <= i_wdata[`AODR_CMD2_RANGE_CH1];
    end
  end
  assign o_range_select_ch0 = range0_q;
  assign o_range_select_ch1 = range1_q;

  // Port direction, 1 means input; ports start as inputs so nothing drives
  logic pa_in_q, pb_in_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pa_in_q <= 1'b1;
      pb_in_q <= 1'b1;
    end else if (wr_cfg) begin
      pa_in_q <= i_wdata[`AODR_CFG_FIRST_IN];
      pb_in_q <= i_wdata[`AODR_CFG_SECOND_IN];
    end
  end

  // Config clears both latches; plain latched data
  aodr_byte_t pa_q, pb_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || wr_cfg) begin
      pa_q <= `AODR_PORT_RESET;
      pb_q <= `AODR_PORT_RESET;
    end else begin
      if (wr_pa) pa_q <= i_wdata;
      if (wr_pb) pb_q <= i_wdata;
    end
  end

  // Drive only while configured as output
  aodr_byte_t pa_oe_q, pb_oe_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pa_oe_q <= 8'h00;
      pb_oe_q <= 8'h00;
    end else begin
      pa_oe_q <= {8{~pa_in_q}};
      pb_oe_q <= {8{~pb_in_q}};
    end
  end
  assign o_first_port_lines = pa_q;
  assign o_second_port_lines = pb_q;
  assign o_first_port_lines_oe = pa_oe_q;
  assign o_second_port_lines_oe = pb_oe_q;

  // Read mux; write-only offsets read zero, no side effect
  aodr_byte_t rdata_d;
  always_comb begin
    case (i_addr)
      `AODR_OFS_PORT_FIRST: rdata_d = pa_sync_q;
      `AODR_OFS_PORT_SECOND: rdata_d = pb_sync_q;
      `AODR_OFS_CAL_READ: rdata_d = {7'h00, prom_sync_q};
      default: rdata_d = 8'h00;
    endcase
  end

  aodr_byte_t rdata_q;
  logic rvalid_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_rd;
      if (i_rd) rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
endmodule : aodr_register_bank
`default_nettype wire

// [bench/aodr_pin_model.sv]
/*
  Far side of one digital port: a wire pulled by the bank or the field.
  Assumes the bank drives each line only while its enable bit is high.
*/
`timescale 1ns/100ps
`default_nettype none
module aodr_pin_model (
  // Bank side
  input wire aodr_pkg::aodr_byte_t i_drive,
  input wire aodr_pkg::aodr_byte_t i_oe,
  // Field side
  input wire aodr_pkg::aodr_byte_t i_far,
  output aodr_pkg::aodr_byte_t o_level
);
  import aodr_pkg::*;
  assign o_level = (i_drive & i_oe) | (i_far & ~i_oe);
endmodule : aodr_pin_model
`default_nettype wire

// [bench/aodr_bank_chk.sv]
/*
  Port checker of the register bank.
  Assumes one-cycle strobes and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module aodr_bank_chk #(parameter int CODE_W = 12) (
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire aodr_pkg::aodr_addr_t i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire aodr_pkg::aodr_byte_t i_wdata,
  input wire aodr_pkg::aodr_byte_t o_rdata,
  input wire logic o_rvalid,
  input wire logic [CODE_W-1:0] o_ch0_code,
  input wire logic o_ch0_update,
  input wire logic o_ch1_update,
  input wire aodr_pkg::aodr_byte_t o_first_port_lines,
  input wire aodr_pkg::aodr_byte_t o_second_port_lines
);
  import aodr_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic lo0 = i_wr && i_addr == 5'h04;
  wire logic hi0 = i_wr && i_addr == 5'h05;
  wire logic hi1 = i_wr && i_addr == 5'h07;
  wire logic cfg = i_wr && i_addr == 5'h13 && i_wdata[7] && !(|(i_wdata & 8'h64));
  rd_answer_a: assert property (i_rd |=> o_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (!i_rd |=> !o_rvalid) else $error("stray read answer");
  lo_silent_a: assert property (lo0 |=> !o_ch0_update) else $error("low byte updated");
  hi0_load_a: assert property (hi0 |=> o_ch0_update) else $error("ch0 not updated");
  hi1_load_a: assert property (hi1 |=> o_ch1_update) else $error("ch1 not updated");
  hi_field_a: assert property (hi0 |=> o_ch0_code[11:8] == $past(i_wdata[3:0]))
    else $error("high code bits wrong");
  code_hold_a: assert property (!hi0 |=> $stable(o_ch0_code)) else $error("code moved");
  cfg_clear_a: assert property (
    cfg |=> (o_first_port_lines | o_second_port_lines) == 8'h00)
    else $error("latches not cleared");
  wo_read_a: assert property (i_rd && i_addr == 5'h05 |=> o_rdata == 8'h00)
    else $error("write-only read not zero");
  cover property (hi0 ##1 o_ch0_update);
  cover property (hi1 ##1 o_ch1_update);
  cover property (cfg);
endmodule : aodr_bank_chk
bind aodr_register_bank aodr_bank_chk #(.CODE_W(CODE_W)) u_aodr_bank_chk (.*);
`default_nettype wire

// [bench/aodr_register_bank_tb.sv]
/*
  Self-checking bench of the register bank through byte reads and writes.
  Assumes the pin models stand on both digital ports.
*/
`timescale 1ns/100ps
`default_nettype none
module aodr_register_bank_tb;
  import aodr_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ee = 1, rv, u0, u1, t0, t1, r0, r1;
  aodr_addr_t addr = '0;
  aodr_byte_t wd = '0, f1 = 8'hA5, f2 = 8'h3C, rdata, d1, e1, d2, e2, l1, l2;
  logic [11:0] c0, c1;
  int mismatches = 0, tests_run = 0;
  initial forever #2 clk = ~clk;
  aodr_register_bank u_aodr_register_bank (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata), .o_rvalid(rv), .o_ch0_code(c0),
    .o_ch1_code(c1), .o_ch0_update(u0), .o_ch1_update(u1), .o_twos_complement_select_ch0(t0),
    .o_twos_complement_select_ch1(t1), .o_range_select_ch0(r0), .o_range_select_ch1(r1),
    .i_eeprom_serial_readback_bit(ee), .i_first_port_lines(l1), .o_first_port_lines(d1),
    .o_first_port_lines_oe(e1), .i_second_port_lines(l2), .o_second_port_lines(d2),
    .o_second_port_lines_oe(e2));
  aodr_pin_model u_aodr_pin_model (.i_drive(d1), .i_oe(e1), .i_far(f1), .o_level(l1));
  aodr_pin_model u_aodr_pin_model_2 (.i_drive(d2), .i_oe(e2), .i_far(f2), .o_level(l2));
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (e !== s) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wrb(input aodr_addr_t a, input aodr_byte_t d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrb
  task rdb(input aodr_addr_t a, input aodr_byte_t e, input aodr_byte_t m);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 16'h1, {15'h0, rv});
    chk("rdata", {8'h0, e}, {8'h0, rdata & m});
  endtask : rdb
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    #4000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    chk("modes", 16'h0003, {12'h0, t1, t0, r1, r0});
    chk("oe", 16'h0, {e1, e2});
    wrb(5'h04, 8'h34);
    #1;
    chk("lo only", 16'h0, {u0, c0});
    wrb(5'h05, 8'h02);
    #1;
    chk("ch0", 16'h1234, {u0, c0});
    wrb(5'h06, 8'hCD);
    wrb(5'h07, 8'h0B);
    #1;
    chk("ch1", 16'h1BCD, {u1, c1});
    wrb(5'h06, 8'h77);
    #1;
    chk("ch1 staged", 16'h0BCD, {u1, c1});
    wrb(5'h07, 8'h05);
    #1;
    chk("ch1 joined", 16'h1577, {u1, c1});
    wrb(5'h01, 8'h10);
    wrb(5'h0E, 8'h08);
    @(posedge clk);
    #1;
    chk("modes", 16'h0006, {12'h0, t1, t0, r1, r0});
    wrb(5'h04, 8'h34);
    wrb(5'h05, 8'hFA);
    #1;
    chk("ch0 signed", 16'h1A34, {u0, c0});
    rdb(5'h05, 8'h00, 8'hFF);
    chk("ch0 kept", 16'h0A34, {4'h0, c0});
    rdb(5'h1D, 8'h01, 8'h01);
    @(posedge clk);
    ee <= 1'b0;
    repeat (3) @(posedge clk);
    rdb(5'h1D, 8'h00, 8'h01);
    $display("analog tests done");
    wrb(5'h13, 8'h80);
    wrb(5'h10, 8'h12);
    wrb(5'h11, 8'h34);
    repeat (4) @(posedge clk);
    rdb(5'h10, 8'h12, 8'hFF);
    rdb(5'h11, 8'h34, 8'hFF);
    wrb(5'h13, 8'h82);
    repeat (4) @(posedge clk);
    #1;
    chk("oe", 16'hFF00, {e1, e2});
    rdb(5'h10, 8'h00, 8'hFF);
    rdb(5'h11, 8'h3C, 8'hFF);
    wrb(5'h10, 8'h55);
    wrb(5'h13, 8'h02);
    wrb(5'h13, 8'h84);
    repeat (4) @(posedge clk);
    rdb(5'h10, 8'h55, 8'hFF);
    $display("port tests done");
    complete_run;
  end
endmodule : aodr_register_bank_tb
`default_nettype wire
